// *** hw/spio_params.svh ***
`ifndef SPIO_PARAMS_SVH
`define SPIO_PARAMS_SVH
// Register byte offsets, one aligned word each
`define SPIO_OFS_E_DATA  8'h00
`define SPIO_OFS_E_DIR   8'h04
`define SPIO_OFS_F_DATA  8'h08
`define SPIO_OFS_F_DIR   8'h0c
`define SPIO_OFS_G_DATA  8'h10
`define SPIO_OFS_G_DIR   8'h14
`define SPIO_OFS_G_PULL  8'h18
`define SPIO_OFS_CTRL    8'h1c
`define SPIO_OFS_STATUS  8'h20
// Implemented pin masks
`define SPIO_MASK_E      8'hff
`define SPIO_MASK_F      8'h07
`define SPIO_MASK_G      8'h06
// Control register fields
`define SPIO_CTRL_SPL    0
`define SPIO_CTRL_PORT_INPUT_CONTROL  1
`define SPIO_CTRL_SEGSEL 8
// Reset values
`define SPIO_RST_BYTE    8'h00
`define SPIO_RST_SEGSEL  8'h00
`endif

// *** hw/spio_pkg.sv ***
package spio_pkg;
  typedef logic [7:0] spio_byte_t;
  typedef enum logic [1:0] {
    SPIO_IDLE = 2'b01,
    SPIO_ACK  = 2'b10
  } spio_bus_st_t;
endpackage

// *** hw/spio_ports.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "spio_params.svh"

// Summary of operation
// - Direction 0 makes pin an input
// - Direction 1 drives pin from latch
// - Data writes always latch, reach outputs only
// - Input pin reads pin; READ_MODIFY_WRITE_ACCESS reads latch
// - Output pin reads return latch value
// - Peripheral may drive; reads see pin where direction is 0, latch where 1
// - Peripheral inputs: direction 0, read pin
// - Segment select 1 with input control 1 gives segment output
// - Reset clears all direction bits
// - Standby with pin-state 1 floats pins
// - Standby with pin-state 0 keeps pins
// - Open-drain pin floats when latch 1
// - Port G has pull-up control register
// - Pull-up off while pin drives low
module spio_ports #(
  parameter logic [7:0] OPEN_DRAIN_F = 8'h04
) (
  input  wire logic        CLK,
  input  wire logic        NRST,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  input  wire logic        RMW_READ,
  input  wire logic        STANDBY_STOP_WATCH,
  input  wire logic [7:0]  PE_IN,
  output logic      [7:0]  PE_OUT,
  output logic      [7:0]  PE_OE,
  input  wire logic [7:0]  PF_IN,
  output logic      [7:0]  PF_OUT,
  output logic      [7:0]  PF_OE,
  input  wire logic [7:0]  PG_IN,
  output logic      [7:0]  PG_OUT,
  output logic      [7:0]  PG_OE,
  output logic      [7:0]  PG_PULLUP,
  input  wire logic [7:0]  PERI_E_OE,
  input  wire logic [7:0]  PERI_E_OUT,
  input  wire logic [7:0]  SEG_E_OUT,
  output logic      [7:0]  PE_TO_PERI,
  output logic      [7:0]  PF_TO_PERI,
  output logic      [7:0]  PG_TO_PERI
);

  spio_pkg::spio_byte_t e_lat_q, e_dir_q, f_lat_q, f_dir_q;
  spio_pkg::spio_byte_t g_lat_q, g_dir_q, g_pul_q, segsel_q;
  logic                 spl_q, port_input_control_q;
  spio_pkg::spio_bus_st_t st_q;
  logic [7:0] e_s1_q, e_s2_q, e_s3_q, e_pin_q;
  logic [7:0] f_s1_q, f_s2_q, f_s3_q, f_pin_q;
  logic [7:0] g_s1_q, g_s2_q, g_s3_q, g_pin_q;
  logic [7:0] e_oe, f_oe, g_oe, e_drv, f_drv, g_drv;
  logic       req, wr, float_all, hold_pins;
  logic [7:0] e_in, f_in, g_in;

  // Byte write helper honouring the pin mask; lane 0 is checked in wr
  function automatic logic [7:0] wmerge(input logic [7:0] old,
                                        input logic [7:0] nv,
                                        input logic [7:0] msk);
    wmerge = (nv & msk) | (old & ~msk);
  endfunction

  // Read: latch for outputs or READ_MODIFY_WRITE_ACCESS, synchronised pin otherwise
  function automatic logic [7:0] rdport(input logic [7:0] lat,
                                        input logic [7:0] dir,
                                        input logic [7:0] pin,
                                        input logic       read_modify_write_access,
                                        input logic [7:0] msk);
    logic [7:0] sel;
    sel = read_modify_write_access ? 8'hff : dir;
    rdport = ((lat & sel) | (pin & ~sel)) & msk;
  endfunction

  assign req = WB_CYC_I & WB_STB_I & (st_q == spio_pkg::SPIO_IDLE);
  assign wr  = req & WB_WE_I & WB_SEL_I[0];
  assign WB_ACK_O = (st_q == spio_pkg::SPIO_ACK);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      st_q <= spio_pkg::SPIO_IDLE;
    end else begin
      case (st_q)
        spio_pkg::SPIO_IDLE: if (req) st_q <= spio_pkg::SPIO_ACK;
        spio_pkg::SPIO_ACK:  st_q <= spio_pkg::SPIO_IDLE;
        default:             st_q <= spio_pkg::SPIO_IDLE;
      endcase
    end
  end

  // Data latches take every write whatever the direction
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      e_lat_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_E_DATA) begin
      e_lat_q <= wmerge(e_lat_q, WB_DAT_I[7:0], `SPIO_MASK_E);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      f_lat_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_F_DATA) begin
      f_lat_q <= wmerge(f_lat_q, WB_DAT_I[7:0], `SPIO_MASK_F);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      g_lat_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_G_DATA) begin
      g_lat_q <= wmerge(g_lat_q, WB_DAT_I[7:0], `SPIO_MASK_G);
    end
  end

  // Directions reset to inputs so no pin drives before software asks
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      e_dir_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_E_DIR) begin
      e_dir_q <= wmerge(e_dir_q, WB_DAT_I[7:0], `SPIO_MASK_E);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      f_dir_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_F_DIR) begin
      f_dir_q <= wmerge(f_dir_q, WB_DAT_I[7:0], `SPIO_MASK_F);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      g_dir_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_G_DIR) begin
      g_dir_q <= wmerge(g_dir_q, WB_DAT_I[7:0], `SPIO_MASK_G);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      g_pul_q <= `SPIO_RST_BYTE;
    end else if (wr && WB_ADR_I == `SPIO_OFS_G_PULL) begin
      g_pul_q <= wmerge(g_pul_q, WB_DAT_I[7:0], `SPIO_MASK_G);
    end
  end

  // Control: standby pin-state and input control sit in lane 0
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      spl_q   <= 1'b0;
      port_input_control_q <= 1'b0;
    end else if (wr && WB_ADR_I == `SPIO_OFS_CTRL) begin
      spl_q   <= WB_DAT_I[`SPIO_CTRL_SPL];
      port_input_control_q <= WB_DAT_I[`SPIO_CTRL_PORT_INPUT_CONTROL];
    end
  end

  // Segment selects sit in lane 1
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      segsel_q <= `SPIO_RST_SEGSEL;
    end else if (req && WB_WE_I && WB_SEL_I[1] &&
                 WB_ADR_I == `SPIO_OFS_CTRL) begin
      segsel_q <= WB_DAT_I[`SPIO_CTRL_SEGSEL +: 8];
    end
  end

  // Three-stage pin sampling; level accepted once stages 2 and 3 agree
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      e_s1_q <= 8'h00;
      e_s2_q <= 8'h00;
      e_s3_q <= 8'h00;
    end else begin
      e_s1_q <= PE_IN;
      e_s2_q <= e_s1_q;
      e_s3_q <= e_s2_q;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      f_s1_q <= 8'h00;
      f_s2_q <= 8'h00;
      f_s3_q <= 8'h00;
    end else begin
      f_s1_q <= PF_IN;
      f_s2_q <= f_s1_q;
      f_s3_q <= f_s2_q;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      g_s1_q <= 8'h00;
      g_s2_q <= 8'h00;
      g_s3_q <= 8'h00;
    end else begin
      g_s1_q <= PG_IN;
      g_s2_q <= g_s1_q;
      g_s3_q <= g_s2_q;
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_filt
      always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
          e_pin_q[i] <= 1'b0;
          f_pin_q[i] <= 1'b0;
          g_pin_q[i] <= 1'b0;
        end else begin
          if (e_s2_q[i] == e_s3_q[i]) e_pin_q[i] <= e_s3_q[i];
          if (f_s2_q[i] == f_s3_q[i]) f_pin_q[i] <= f_s3_q[i];
          if (g_s2_q[i] == g_s3_q[i]) g_pin_q[i] <= g_s3_q[i];
        end
      end
    end
  endgenerate

  // Segment drive wins when selected and input control is set; the
  // port driver is expected to be off there, so segments override it
  always_comb begin
    float_all = STANDBY_STOP_WATCH & spl_q;
    e_drv = 8'h00;
    e_oe  = 8'h00;
    for (int b = 0; b < 8; b++) begin
      if (port_input_control_q && segsel_q[b]) begin
        e_drv[b] = SEG_E_OUT[b];
        e_oe[b]  = 1'b1;
      end else if (PERI_E_OE[b]) begin
        e_drv[b] = PERI_E_OUT[b];
        e_oe[b]  = 1'b1;
      end else begin
        e_drv[b] = e_lat_q[b];
        e_oe[b]  = e_dir_q[b];
      end
    end
    f_drv = f_lat_q;
    f_oe  = f_dir_q & ~(OPEN_DRAIN_F & f_lat_q);
    g_drv = g_lat_q;
    g_oe  = g_dir_q;
  end

  // Pin-state 0 in standby freezes every pin output where it stands
  assign hold_pins = STANDBY_STOP_WATCH & ~spl_q;

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PE_OUT <= 8'h00;
      PE_OE  <= 8'h00;
    end else if (!hold_pins) begin
      PE_OUT <= e_drv;
      PE_OE  <= float_all ? 8'h00 : (e_oe & `SPIO_MASK_E);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PF_OUT <= 8'h00;
      PF_OE  <= 8'h00;
    end else if (!hold_pins) begin
      PF_OUT <= f_drv & `SPIO_MASK_F;
      PF_OE  <= float_all ? 8'h00 : (f_oe & `SPIO_MASK_F);
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PG_OUT <= 8'h00;
      PG_OE  <= 8'h00;
    end else if (!hold_pins) begin
      PG_OUT <= g_drv & `SPIO_MASK_G;
      PG_OE  <= float_all ? 8'h00 : (g_oe & `SPIO_MASK_G);
    end
  end

  // Pull-up shares the freeze; dropped while the pin drives low
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PG_PULLUP <= 8'h00;
    end else if (!hold_pins) begin
      PG_PULLUP <= float_all ? 8'h00 :
                   (g_pul_q & ~(g_oe & ~g_drv) & `SPIO_MASK_G);
    end
  end

  // Inputs to peripherals are blocked low in floating standby
  assign e_in = float_all ? 8'h00 : e_pin_q;
  assign f_in = float_all ? 8'h00 : (f_pin_q & `SPIO_MASK_F);
  assign g_in = float_all ? 8'h00 : (g_pin_q & `SPIO_MASK_G);

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      PE_TO_PERI <= 8'h00;
      PF_TO_PERI <= 8'h00;
      PG_TO_PERI <= 8'h00;
    end else begin
      PE_TO_PERI <= e_in;
      PF_TO_PERI <= f_in;
      PG_TO_PERI <= g_in;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (req && !WB_WE_I) begin
      if (WB_ADR_I == `SPIO_OFS_E_DATA) begin
        WB_DAT_O <= {24'h0, rdport(e_lat_q, e_dir_q, e_in,
                                   RMW_READ, `SPIO_MASK_E)};
      end else if (WB_ADR_I == `SPIO_OFS_F_DATA) begin
        WB_DAT_O <= {24'h0, rdport(f_lat_q, f_dir_q, f_in,
                                   RMW_READ, `SPIO_MASK_F)};
      end else if (WB_ADR_I == `SPIO_OFS_G_DATA) begin
        WB_DAT_O <= {24'h0, rdport(g_lat_q, g_dir_q, g_in,
                                   RMW_READ, `SPIO_MASK_G)};
      end else if (WB_ADR_I == `SPIO_OFS_E_DIR) begin
        WB_DAT_O <= {24'h0, e_dir_q};
      end else if (WB_ADR_I == `SPIO_OFS_F_DIR) begin
        WB_DAT_O <= {24'h0, f_dir_q};
      end else if (WB_ADR_I == `SPIO_OFS_G_DIR) begin
        WB_DAT_O <= {24'h0, g_dir_q};
      end else if (WB_ADR_I == `SPIO_OFS_G_PULL) begin
        WB_DAT_O <= {24'h0, g_pul_q};
      end else if (WB_ADR_I == `SPIO_OFS_CTRL) begin
        WB_DAT_O <= {16'h0, segsel_q, 6'h0, port_input_control_q, spl_q};
      end else if (WB_ADR_I == `SPIO_OFS_STATUS) begin
        WB_DAT_O <= {31'h0, float_all};
      end else begin
        WB_DAT_O <= 32'h0000_0000;
      end
    end
  end

endmodule // spio_ports
`default_nettype wire

// *** tb/spio_ports_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "spio_params.svh"
module spio_ports_asserts #(
  parameter logic [7:0] OPEN_DRAIN_F = 8'h04
) (
  input wire logic        CLK,
  input wire logic        NRST,
  input wire logic        WB_CYC_I,
  input wire logic        WB_STB_I,
  input wire logic        WB_WE_I,
  input wire logic [7:0]  WB_ADR_I,
  input wire logic [3:0]  WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic        WB_ACK_O,
  input wire logic        STANDBY_STOP_WATCH,
  input wire logic [7:0]  PE_OE,
  input wire logic [7:0]  PF_OUT,
  input wire logic [7:0]  PF_OE,
  input wire logic [7:0]  PG_OUT,
  input wire logic [7:0]  PG_OE,
  input wire logic [7:0]  PG_PULLUP
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence s_wr(logic [7:0] a);
    s_req ##0 (WB_WE_I && WB_SEL_I[0] && !STANDBY_STOP_WATCH &&
      WB_ADR_I == a);
  endsequence
  chk_ack_next: assert property (s_req |=> WB_ACK_O)
    else $error("ack late");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack too long");
  chk_f_dir: assert property (s_wr(`SPIO_OFS_F_DIR) |-> ##2
    PF_OE[1:0] == $past(WB_DAT_I[1:0], 2)) else $error("port F enable");
  chk_f_data: assert property (s_wr(`SPIO_OFS_F_DATA) |-> ##2
    (PF_OUT[1:0] & PF_OE[1:0]) == ($past(WB_DAT_I[1:0], 2) & PF_OE[1:0]))
    else $error("port F drive");
  chk_g_mask: assert property (s_wr(`SPIO_OFS_G_DIR) |-> ##2
    PG_OE == ($past(WB_DAT_I[7:0], 2) & `SPIO_MASK_G))
    else $error("port G enable");
  chk_reset_oe: assert property ($rose(NRST) |->
    (PE_OE | PF_OE | PG_OE) == 8'h00) else $error("enable after reset");
  chk_pull_low: assert property (
    (PG_PULLUP & PG_OE & ~PG_OUT) == 8'h00) else $error("pull-up on low");
  chk_od_high: assert property (
    (PF_OE & PF_OUT & OPEN_DRAIN_F) == 8'h00) else $error("open drain high");
  chk_unmapped_rd: assert property (s_req ##0
    (!WB_WE_I && WB_ADR_I == 8'h40) |=> WB_DAT_O == 32'h0)
    else $error("unmapped read");
endmodule // spio_ports_asserts
bind spio_ports spio_ports_asserts #(.OPEN_DRAIN_F(OPEN_DRAIN_F)) u_chk (
  .CLK(CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I),
  .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .STANDBY_STOP_WATCH(STANDBY_STOP_WATCH), .PE_OE(PE_OE),
  .PF_OUT(PF_OUT), .PF_OE(PF_OE), .PG_OUT(PG_OUT), .PG_OE(PG_OE),
  .PG_PULLUP(PG_PULLUP));
`default_nettype wire

// *** tb/spio_pins_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module spio_pins_model (
  input  wire logic       clk,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] out,
  input  wire logic [7:0] pull,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext,
  output logic      [7:0] pin
);
  // A floating pin wanders so that a stale value never reads as a match
  logic [7:0] wobble_q = 8'h00;
  always_ff @(posedge clk) wobble_q <= wobble_q + 8'h5b;
  assign pin = (oe & out) | (~oe & ext_en & ext)
             | (~oe & ~ext_en & (pull | wobble_q));
endmodule // spio_pins_model
`default_nettype wire

// *** tb/spio_ports_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "spio_params.svh"
module spio_ports_tb;
  logic        clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, read_modify_write_access = 1'b0, stby = 1'b0, ack;
  logic [7:0]  adr = 8'h00, p_oe = 8'h00, p_out = 8'h00, seg = 8'h00;
  logic [7:0]  ext = 8'h00, ext_en = 8'h00, eo, eoe, fo, foe, go, goe;
  logic [7:0]  gpu, ep, fp, gp, e_to, f_to, g_to;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, q;
  int          errors = 0, n_checks = 0;
  always #50 clk = ~clk;
  spio_ports dut (.CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
    .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat),
    .WB_DAT_O(rdat), .WB_ACK_O(ack), .RMW_READ(read_modify_write_access),
    .STANDBY_STOP_WATCH(stby), .PE_IN(ep), .PE_OUT(eo), .PE_OE(eoe),
    .PF_IN(fp), .PF_OUT(fo), .PF_OE(foe), .PG_IN(gp), .PG_OUT(go),
    .PG_OE(goe), .PG_PULLUP(gpu), .PERI_E_OE(p_oe), .PERI_E_OUT(p_out),
    .SEG_E_OUT(seg), .PE_TO_PERI(e_to), .PF_TO_PERI(f_to),
    .PG_TO_PERI(g_to));
  spio_pins_model m_e (.clk(clk), .oe(eoe), .out(eo), .pull(8'h00),
    .ext_en(ext_en), .ext(ext), .pin(ep));
  spio_pins_model m_f (.clk(clk), .oe(foe), .out(fo), .pull(8'h00),
    .ext_en(ext_en), .ext(ext), .pin(fp));
  spio_pins_model m_g (.clk(clk), .oe(goe), .out(go), .pull(gpu),
    .ext_en(8'h00), .ext(8'h00), .pin(gp));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic r);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    read_modify_write_access <= r;
    sel <= 4'h3;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 1'b0);
  endtask
  task automatic rdc(input logic [7:0] a, input logic r, input logic [31:0] e);
    wb(1'b0, a, 32'h0, r);
    chk(q, e);
  endtask
  // Input sync plus filter needs about four edges
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask
  task automatic t_reset();
    rdc(`SPIO_OFS_E_DIR, 1'b0, 32'h0);
    rdc(`SPIO_OFS_F_DIR, 1'b0, 32'h0);
    chk({eoe, foe, goe}, 24'h0);
    $display("reset test done");
  endtask
  task automatic t_out();
    wr(`SPIO_OFS_F_DIR, 32'h07);
    wr(`SPIO_OFS_F_DATA, 32'hff);
    settle();
    chk(foe, 8'h03);
    rdc(`SPIO_OFS_F_DATA, 1'b0, 32'h07);
    wr(`SPIO_OFS_F_DATA, 32'h02);
    settle();
    chk({foe, fo & foe}, 16'h0702);
    chk(f_to, 8'h02);
    $display("output test done");
  endtask
  task automatic t_in();
    ext_en <= 8'hff;
    ext <= 8'ha5;
    wr(`SPIO_OFS_E_DATA, 32'h3c);
    settle();
    chk(eoe, 8'h00);
    rdc(`SPIO_OFS_E_DATA, 1'b0, 32'ha5);
    rdc(`SPIO_OFS_E_DATA, 1'b1, 32'h3c);
    wr(`SPIO_OFS_E_DIR, 32'hf0);
    settle();
    rdc(`SPIO_OFS_E_DATA, 1'b0, 32'h35);
    $display("input test done");
  endtask
  task automatic t_peri();
    p_oe <= 8'h0f;
    p_out <= 8'h09;
    settle();
    chk(eoe, 8'hff);
    rdc(`SPIO_OFS_E_DATA, 1'b0, 32'h39);
    rdc(`SPIO_OFS_E_DATA, 1'b1, 32'h3c);
    p_oe <= 8'h00;
    wr(`SPIO_OFS_E_DIR, 32'h00);
    settle();
    chk(e_to, 8'ha5);
    rdc(`SPIO_OFS_E_DATA, 1'b0, 32'ha5);
    $display("peripheral test done");
  endtask
  task automatic t_seg();
    seg <= 8'hc3;
    wr(`SPIO_OFS_CTRL, 32'hff02);
    settle();
    chk({eoe, eo}, 16'hffc3);
    wr(`SPIO_OFS_CTRL, 32'h0002);
    settle();
    chk(eoe, 8'h00);
    $display("segment test done");
  endtask
  task automatic t_mask();
    wr(`SPIO_OFS_G_DIR, 32'hff);
    rdc(`SPIO_OFS_G_DIR, 1'b0, 32'h06);
    wr(`SPIO_OFS_G_PULL, 32'hff);
    rdc(`SPIO_OFS_G_PULL, 1'b0, 32'h06);
    wr(`SPIO_OFS_G_DATA, 32'h00);
    settle();
    chk(gpu, 8'h00);
    wr(`SPIO_OFS_G_DATA, 32'h06);
    settle();
    chk(gpu, 8'h06);
    chk({go, g_to}, 16'h0606);
    wr(8'h40, 32'hffffffff);
    rdc(8'h40, 1'b0, 32'h0);
    $display("mask test done");
  endtask
  task automatic t_stby();
    wr(`SPIO_OFS_CTRL, 32'h0003);
    stby <= 1'b1;
    settle();
    chk({eoe, foe, goe, gpu, e_to}, 40'h0);
    rdc(`SPIO_OFS_STATUS, 1'b0, 32'h1);
    stby <= 1'b0;
    wr(`SPIO_OFS_CTRL, 32'h0002);
    stby <= 1'b1;
    wr(`SPIO_OFS_F_DIR, 32'h00);
    settle();
    chk({foe, goe, gpu}, 24'h070606);
    rdc(`SPIO_OFS_F_DIR, 1'b0, 32'h0);
    stby <= 1'b0;
    $display("standby test done");
  endtask
  task automatic t_rerun();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    chk({eoe, foe, goe, gpu}, 32'h0);
    nrst <= 1'b1;
    rdc(`SPIO_OFS_G_DIR, 1'b0, 32'h0);
    rdc(`SPIO_OFS_E_DIR, 1'b0, 32'h0);
    $display("second reset test done");
  endtask
  initial begin
    #(5000 * 100);
    errors++;
    close_out();
  end
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_out();
    t_in();
    t_peri();
    t_seg();
    t_mask();
    t_stby();
    t_rerun();
    close_out();
  end
endmodule // spio_ports_tb
`default_nettype wire
